// [core/tec_checker.sv]
// Purpose: Transaction-layer error classification for a switch bridge function
// Assumes: One TLP header per valid cycle, fields decoded upstream
// Notes:   Verdict and header log registered one cycle after the TLP
`timescale 1ns/1ps
`default_nettype none

module tec_checker #(
	parameter int NUM_FUNC = 2
) (
	input  wire logic                     clk_i,
	input  wire logic                     nrst_i,
	input  wire tec_pkg::tec_tlp_type     tlp_i,
	input  wire logic [NUM_FUNC-1:0]      func_ecrc_en_i,
	input  wire logic [NUM_FUNC-1:0]      func_select_i,
	input  wire logic                     sev_unexp_cpl_i,
	input  wire logic                     sev_ecrc_i,
	input  wire logic                     sev_ur_i,
	input  wire logic [2:0]               max_payload_size_field_i,
	input  wire logic [7:0]               class_to_channel_map_i,
	input  wire logic                     bridge_d3hot_i,
	input  wire logic                     link_down_i,
	output tec_pkg::tec_verdict_type      verdict_o,
	output logic                          event_valid_o,
	output logic [127:0]                  hdr_log_o,
	output logic                          port_ecrc_en_o,
	output logic                          pri_target_abort_o,
	output logic                          sec_target_abort_o,
	output tec_pkg::tec_cpl_src_type      ur_cpl_src_o
);

	// ------------------------------------------------------------
	// Pin synchronisers for the two power/link levels
	// ------------------------------------------------------------
	logic [1:0] d3_sync_d;
	logic [1:0] d3_sync_q;
	logic [1:0] ld_sync_d;
	logic [1:0] ld_sync_q;

	always_comb begin
		d3_sync_d = {d3_sync_q[0], bridge_d3hot_i};
		ld_sync_d = {ld_sync_q[0], link_down_i};
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			d3_sync_q <= 2'h0;
			ld_sync_q <= 2'h0;
		end else begin
			d3_sync_q <= d3_sync_d;
			ld_sync_q <= ld_sync_d;
		end
	end

	// ------------------------------------------------------------
	// Classification
	// ------------------------------------------------------------
	logic                      form_bad;
	logic                      port_ecrc_en;
	logic                      sel_ecrc_en;
	logic                      is_msg;
	logic                      is_vdm;
	logic                      msg_code_ok;
	logic                      is_posted;
	logic                      ur;
	logic                      ur_adv;
	logic                      malformed;
	logic                      ecrc_fail;
	logic                      ecrc_log;
	tec_pkg::tec_verdict_type  verdict_d;
	tec_pkg::tec_verdict_type  verdict_q;
	logic                      ev_d;
	logic                      ev_q;
	logic [127:0]              hdr_d;
	logic [127:0]              hdr_q;
	logic                      pta_d;
	logic                      pta_q;
	logic                      sta_d;
	logic                      sta_q;
	tec_pkg::tec_cpl_src_type  cpl_d;
	tec_pkg::tec_cpl_src_type  cpl_q;

	tec_form_check u_form (
		.hdr_i       (tlp_i.hdr),
		.actual_dw_i (tlp_i.actual_dw),
		.mps_i       (max_payload_size_field_i),
		.tc_vc_map_i (class_to_channel_map_i),
		.malformed_o (form_bad)
	);

	always_comb begin
		port_ecrc_en = |func_ecrc_en_i;
		sel_ecrc_en  = |(func_ecrc_en_i & func_select_i);
		is_msg       = (tlp_i.hdr.typ[4:2] == tec_pkg::TYPE_MSG_HI);
		is_vdm       = is_msg && ((tlp_i.hdr.msg_code == tec_pkg::MSG_VDM0)
			|| (tlp_i.hdr.msg_code == tec_pkg::MSG_VDM1));
		unique case (tlp_i.hdr.msg_code)
			8'h00, 8'h10, 8'h14, 8'h18, 8'h19, 8'h1B, 8'h20, 8'h21, 8'h22, 8'h23,
			8'h24, 8'h25, 8'h26, 8'h27, 8'h30, 8'h31, 8'h33, 8'h50, 8'h7E, 8'h7F:
				msg_code_ok = 1'b1;
			default: msg_code_ok = 1'b0;
		endcase
		is_posted = is_msg || ((tlp_i.hdr.typ == tec_pkg::TYPE_MEM) && tlp_i.hdr.fmt[1]);
		malformed = tlp_i.from_link && form_bad;
		ecrc_fail = port_ecrc_en && tlp_i.hdr.td && tlp_i.ecrc_bad
			&& sel_ecrc_en;
		ecrc_log  = tlp_i.to_bridge || tlp_i.from_link;
		ur = tlp_i.to_bridge && (
			(is_msg && (tlp_i.hdr.msg_code == tec_pkg::MSG_VDM0))
			|| (is_msg && !msg_code_ok)
			|| (tlp_i.hdr.ep && tlp_i.hdr.fmt[1] && !is_vdm
				&& (is_msg || tlp_i.hdr.typ == tec_pkg::TYPE_IO
				|| tlp_i.hdr.typ == tec_pkg::TYPE_MEM))
			|| d3_sync_q[1]);
		ur = ur || (tlp_i.downstream && ld_sync_q[1]);
		ur_adv = sev_ur_i && !is_posted;

		verdict_d = '0;
		verdict_d.fc_err = 1'b0;
		ev_d  = 1'b0;
		hdr_d = hdr_q;
		pta_d = 1'b0;
		sta_d = 1'b0;
		cpl_d = tec_pkg::TEC_CPL_NONE;
		if (tlp_i.valid && !tlp_i.phy_dll_err) begin
			if (tlp_i.overflow) begin
				verdict_d.overflow_err = 1'b1;
				verdict_d.uncor        = 1'b1;
				verdict_d.nullify      = 1'b1;
			end else if (malformed) begin
				verdict_d.malformed = 1'b1;
				verdict_d.uncor     = 1'b1;
				verdict_d.log_hdr   = 1'b1;
				verdict_d.nullify   = 1'b1;
			end else if (tlp_i.mc_blocked) begin
				verdict_d.mc_err  = 1'b1;
				verdict_d.uncor   = 1'b1;
				verdict_d.log_hdr = 1'b1;
				verdict_d.nullify = 1'b1;
				pta_d = !tlp_i.on_secondary;
				sta_d = tlp_i.on_secondary;
			end else if (tlp_i.unexp_cpl) begin
				verdict_d.unexp_err = 1'b1;
				verdict_d.cor       = sev_unexp_cpl_i;
				verdict_d.uncor     = !sev_unexp_cpl_i;
				verdict_d.log_hdr   = 1'b1;
				verdict_d.drop      = 1'b1;
			end else if (ur) begin
				verdict_d.unsupported = 1'b1;
				verdict_d.cor         = ur_adv;
				verdict_d.uncor       = !ur_adv;
				verdict_d.log_hdr     = 1'b1;
				if (!is_posted) begin
					cpl_d = tlp_i.claimed ? tec_pkg::TEC_CPL_CLAIMER
						: tec_pkg::TEC_CPL_FUNC0;
				end
			end else if (ecrc_fail) begin
				verdict_d.ecrc_err = 1'b1;
				verdict_d.cor      = sev_ecrc_i && !tlp_i.to_bridge && tlp_i.from_link;
				verdict_d.uncor    = !(sev_ecrc_i && !tlp_i.to_bridge && tlp_i.from_link);
				verdict_d.log_hdr  = ecrc_log;
				verdict_d.drop     = tlp_i.to_bridge;
			end
			ev_d = verdict_d.cor || verdict_d.uncor;
			if (verdict_d.log_hdr) begin
				hdr_d = tlp_i.raw_hdr;
			end
		end
	end

	// ------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			verdict_q <= '0;
			ev_q      <= 1'b0;
			hdr_q     <= tec_pkg::HDR_RST;
			pta_q     <= 1'b0;
			sta_q     <= 1'b0;
			cpl_q     <= tec_pkg::TEC_CPL_NONE;
		end else begin
			verdict_q <= verdict_d;
			ev_q      <= ev_d;
			hdr_q     <= hdr_d;
			pta_q     <= pta_d;
			sta_q     <= sta_d;
			cpl_q     <= cpl_d;
		end
	end

	assign verdict_o          = verdict_q;
	assign event_valid_o      = ev_q;
	assign hdr_log_o          = hdr_q;
	assign port_ecrc_en_o     = |func_ecrc_en_i;
	assign pri_target_abort_o = pta_q;
	assign sec_target_abort_o = sta_q;
	assign ur_cpl_src_o       = cpl_q;

endmodule

`default_nettype wire

// [pkg/tec_pkg.sv]
// Purpose: Shared types and constants for the transaction-layer error checker
// Assumes: PCIe header fields already extracted by the receive stack
// Notes:   Header fields and verdicts travel as packed structs
package tec_pkg;

	// Format / type encodings (fmt[1:0], type[4:0])
	localparam logic [1:0] FMT_3DW_ND = 2'h0;
	localparam logic [1:0] FMT_4DW_ND = 2'h1;
	localparam logic [1:0] FMT_3DW_D  = 2'h2;
	localparam logic [1:0] FMT_4DW_D  = 2'h3;
	localparam logic [4:0] TYPE_MEM   = 5'h00;
	localparam logic [4:0] TYPE_MEMLK = 5'h01;
	localparam logic [4:0] TYPE_IO    = 5'h02;
	localparam logic [4:0] TYPE_CFG0  = 5'h04;
	localparam logic [4:0] TYPE_CFG1  = 5'h05;
	localparam logic [4:0] TYPE_CPL   = 5'h0A;
	localparam logic [4:0] TYPE_CPLLK = 5'h0B;
	localparam logic [2:0] TYPE_MSG_HI = 3'h6;

	// Message codes
	localparam logic [7:0] MSG_VDM0   = 8'h7E;
	localparam logic [7:0] MSG_VDM1   = 8'h7F;

	// Header sizes in doublewords, ECRC size
	localparam logic [10:0] HDR3_DW   = 11'h003;
	localparam logic [10:0] HDR4_DW   = 11'h004;
	localparam logic [10:0] ECRC_DW   = 11'h001;
	localparam logic [10:0] ONE_DW    = 11'h001;
	localparam logic [3:0]  LAST_BE_ZERO = 4'h0;

	// Reset value of recorded header
	localparam logic [127:0] HDR_RST  = 128'h0;

	typedef struct packed {
		logic [1:0]  fmt;
		logic [4:0]  typ;
		logic [2:0]  tc;
		logic [1:0]  attr;
		logic        td;
		logic        ep;
		logic [9:0]  length;
		logic [3:0]  last_be;
		logic [7:0]  msg_code;
	} tec_hdr_type;

	typedef struct packed {
		logic        valid;
		tec_hdr_type hdr;
		logic [127:0] raw_hdr;
		logic [10:0] actual_dw;
		logic        phy_dll_err;
		logic        ecrc_bad;
		logic        overflow;
		logic        unexp_cpl;
		logic        mc_blocked;
		logic        to_bridge;
		logic        from_link;
		logic        downstream;
		logic        on_secondary;
		logic        claimed;
	} tec_tlp_type;

	typedef struct packed {
		logic        cor;
		logic        uncor;
		logic        log_hdr;
		logic        nullify;
		logic        drop;
		logic        malformed;
		logic        unsupported;
		logic        ecrc_err;
		logic        unexp_err;
		logic        overflow_err;
		logic        mc_err;
		logic        fc_err;
	} tec_verdict_type;

	typedef enum logic [1:0] {
		TEC_CPL_NONE,
		TEC_CPL_CLAIMER,
		TEC_CPL_FUNC0
	} tec_cpl_src_type;

endpackage

// [core/tec_form_check.sv]
// Purpose: Combinational ingress formation checks on one TLP header
// Assumes: Payload length in doublewords, length 0 meaning 1024
// Notes:   Result is a single malformed flag
`timescale 1ns/1ps
`default_nettype none

module tec_form_check (
	input  wire tec_pkg::tec_hdr_type hdr_i,
	input  wire logic [10:0]          actual_dw_i,
	input  wire logic [2:0]           mps_i,
	input  wire logic [7:0]           tc_vc_map_i,
	output logic                      malformed_o
);

	logic        has_data;
	logic        four_dw;
	logic [10:0] pay_dw;
	logic [10:0] mps_dw;
	logic [10:0] hdr_dw;
	logic        bad_type;
	logic        bad_size;
	logic        bad_len;
	logic        bad_ecrc_len;
	logic        bad_io_cfg;
	logic        bad_tc;
	logic        is_io_cfg;
	logic        is_msg;

	always_comb begin
		has_data  = hdr_i.fmt[1];
		four_dw   = hdr_i.fmt[0];
		pay_dw    = (hdr_i.length == 10'h000) ? 11'h400 : {1'b0, hdr_i.length};
		mps_dw    = 11'(11'h020 << mps_i);
		hdr_dw    = four_dw ? tec_pkg::HDR4_DW : tec_pkg::HDR3_DW;
		is_msg    = (hdr_i.typ[4:2] == tec_pkg::TYPE_MSG_HI);
		is_io_cfg = (hdr_i.typ == tec_pkg::TYPE_IO) || (hdr_i.typ == tec_pkg::TYPE_CFG0)
			|| (hdr_i.typ == tec_pkg::TYPE_CFG1);
		// Valid fmt/type pairs
		unique case (hdr_i.typ)
			tec_pkg::TYPE_MEM, tec_pkg::TYPE_MEMLK: bad_type = 1'b0;
			tec_pkg::TYPE_IO, tec_pkg::TYPE_CFG0, tec_pkg::TYPE_CFG1: bad_type = four_dw;
			tec_pkg::TYPE_CPL, tec_pkg::TYPE_CPLLK: bad_type = four_dw;
			default: bad_type = !(is_msg && four_dw);
		endcase
		if (hdr_i.typ == tec_pkg::TYPE_MEMLK && has_data) begin
			bad_type = 1'b1;
		end
		bad_size     = has_data && (pay_dw > mps_dw);
		bad_len      = has_data && (actual_dw_i - hdr_dw - (hdr_i.td ? tec_pkg::ECRC_DW
			: 11'h000) != pay_dw);
		bad_ecrc_len = hdr_i.td && (actual_dw_i != 11'(hdr_dw + (has_data ? pay_dw : 11'h000)
			+ tec_pkg::ECRC_DW));
		bad_io_cfg   = is_io_cfg && ((pay_dw != tec_pkg::ONE_DW) || (hdr_i.tc != 3'h0)
			|| (hdr_i.attr != 2'h0) || (hdr_i.last_be != tec_pkg::LAST_BE_ZERO));
		bad_tc       = !tc_vc_map_i[hdr_i.tc];
		malformed_o  = bad_type || bad_size || bad_len || bad_ecrc_len
			|| bad_io_cfg || bad_tc;
	end

endmodule

`default_nettype wire

// [testbench/tec_monitor.sv]
// Purpose: Port-level checks on the error checker
// Assumes: One clock domain, reset active low
// Notes:   Bound into every checker instance
`timescale 1ns/1ps
`default_nettype none

module tec_monitor #(
	parameter int NUM_FUNC = 2
) (
	input wire logic                     clk_i,
	input wire logic                     nrst_i,
	input wire tec_pkg::tec_tlp_type     tlp_i,
	input wire logic [NUM_FUNC-1:0]      func_ecrc_en_i,
	input wire tec_pkg::tec_verdict_type verdict_o,
	input wire logic                     event_valid_o,
	input wire logic [127:0]             hdr_log_o,
	input wire logic                     port_ecrc_en_o,
	input wire logic                     pri_target_abort_o,
	input wire logic                     sec_target_abort_o
);
	// ----
	// Checks
	// ----
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	a_flow_ctl_none: assert property (!verdict_o.fc_err)
		else $error("flow control error reported");
	a_port_ecrc_or: assert property (port_ecrc_en_o == (|func_ecrc_en_i))
		else $error("port ecrc enable not the or of functions");
	a_phy_quiet: assert property (tlp_i.valid && tlp_i.phy_dll_err |=> !event_valid_o)
		else $error("event on packet with link error");
	a_ovf_no_log: assert property (tlp_i.valid && tlp_i.overflow && !tlp_i.phy_dll_err |=>
		verdict_o.uncor && verdict_o.nullify && !verdict_o.log_hdr)
		else $error("overflow handling wrong");
	a_malf_full: assert property (verdict_o.malformed |->
		verdict_o.uncor && !verdict_o.cor && verdict_o.log_hdr && verdict_o.nullify)
		else $error("malformed handling wrong");
	a_malf_link: assert property (verdict_o.malformed |->
		$past(tlp_i.valid) && $past(tlp_i.from_link))
		else $error("malformed without a link packet");
	a_mc_side: assert property (verdict_o.mc_err |-> verdict_o.uncor &&
		sec_target_abort_o == $past(tlp_i.on_secondary) &&
		pri_target_abort_o != sec_target_abort_o)
		else $error("multicast abort side wrong");
	a_event_kind: assert property (event_valid_o == (verdict_o.cor || verdict_o.uncor))
		else $error("event without severity");
	a_log_take: assert property (verdict_o.log_hdr |-> hdr_log_o == $past(tlp_i.raw_hdr))
		else $error("header log not captured");
	a_log_hold: assert property (!verdict_o.log_hdr |-> $stable(hdr_log_o))
		else $error("header log changed without logging");
	a_unexp_drop: assert property (verdict_o.unexp_err |-> verdict_o.drop &&
		verdict_o.log_hdr && (verdict_o.cor != verdict_o.uncor))
		else $error("unexpected completion handling wrong");

	c_malformed: cover property (verdict_o.malformed);
	c_unsupported: cover property (verdict_o.unsupported);
	c_ecrc: cover property (verdict_o.ecrc_err);
endmodule

bind tec_checker tec_monitor #(.NUM_FUNC(NUM_FUNC)) u_tec_monitor (
	.clk_i(clk_i), .nrst_i(nrst_i), .tlp_i(tlp_i), .func_ecrc_en_i(func_ecrc_en_i),
	.verdict_o(verdict_o), .event_valid_o(event_valid_o), .hdr_log_o(hdr_log_o),
	.port_ecrc_en_o(port_ecrc_en_o), .pri_target_abort_o(pri_target_abort_o),
	.sec_target_abort_o(sec_target_abort_o)
);
`default_nettype wire

// [testbench/tec_link_partner.sv]
// Purpose: Link partner delivering TLP descriptors
// Assumes: One descriptor per valid cycle from the bench
// Notes:   Idle cycles carry inverted stale fields
`timescale 1ns/1ps
`default_nettype none

module tec_link_partner (
	input  wire logic                 clk_i,
	input  wire logic                 nrst_i,
	input  wire tec_pkg::tec_tlp_type desc_i,
	output var  tec_pkg::tec_tlp_type tlp_o
);
	// ----
	// Delivery
	// ----
	tec_pkg::tec_tlp_type idle;

	// Idle word: stale fields inverted, never valid
	always_comb begin
		idle       = ~tlp_o;
		idle.valid = 1'b0;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tlp_o <= '0;
		end else if (desc_i.valid) begin
			tlp_o <= desc_i;
		end else begin
			tlp_o <= idle;
		end
	end
endmodule
`default_nettype wire

// [testbench/tec_checker_tb.sv]
// Purpose: Self-checking bench for the error checker
// Assumes: Verdict one cycle after the partner delivers
// Notes:   Max payload code 0, classes 0 and 1 on channel 0
`timescale 1ns/1ps
`default_nettype none

module tec_checker_tb;
	logic clk_i, nrst_i, sev_u, sev_e, sev_r, d3, ld, ev, pe, pa, sa;
	logic [1:0] fen, fsel;
	logic [2:0] max_payload_size_field;
	logic [7:0] map;
	logic [127:0] hl;
	tec_pkg::tec_tlp_type t, desc, tlp;
	tec_pkg::tec_verdict_type v;
	tec_pkg::tec_cpl_src_type src;
	int errors, n_tests;

	tec_link_partner u_tec_link_partner (.clk_i(clk_i), .nrst_i(nrst_i), .desc_i(desc),
		.tlp_o(tlp));
	tec_checker #(.NUM_FUNC(2)) u_tec_checker (
		.clk_i(clk_i), .nrst_i(nrst_i), .tlp_i(tlp), .func_ecrc_en_i(fen),
		.func_select_i(fsel), .sev_unexp_cpl_i(sev_u), .sev_ecrc_i(sev_e), .sev_ur_i(sev_r),
		.max_payload_size_field_i(max_payload_size_field), .class_to_channel_map_i(map), .bridge_d3hot_i(d3),
		.link_down_i(ld), .verdict_o(v), .event_valid_o(ev), .hdr_log_o(hl),
		.port_ecrc_en_o(pe), .pri_target_abort_o(pa), .sec_target_abort_o(sa),
		.ur_cpl_src_o(src));

	// ----
	// Helpers
	// ----
	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("errors %0d of %0d checks", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic base();
		t = '0;
		t.valid = 1'b1;
		t.hdr.fmt = tec_pkg::FMT_3DW_D;
		t.hdr.length = 10'h001;
		t.actual_dw = 11'h004;
		t.from_link = 1'b1;
		t.claimed = 1'b1;
		t.raw_hdr = 128'hA5C30000 + 128'(n_tests);
	endtask

	task automatic send();
		@(posedge clk_i) desc <= t;
		@(posedge clk_i) desc.valid <= 1'b0;
		@(posedge clk_i);
		#1;
	endtask

	// ----
	// Scenarios
	// ----
	task automatic s_malformed();
		for (int i = 0; i < 8; i++) begin
			base();
			case (i)
				0: t.hdr.typ = 5'h03;
				1: t.hdr.length = 10'h021;
				2: t.hdr.length = 10'h002;
				3: t.hdr.td = 1'b1;
				4: t.hdr.typ = tec_pkg::TYPE_IO;
				5: t.hdr.typ = tec_pkg::TYPE_CFG0;
				6: t.hdr.tc = 3'h2;
				default: t.from_link = 1'b0;
			endcase
			if (i == 3)
				t.hdr.fmt = tec_pkg::FMT_3DW_ND;
			if (i == 3)
				t.actual_dw = 11'h003;
			if (i == 1)
				t.actual_dw = 11'h024;
			if (i == 4)
				t.hdr.last_be = 4'h1;
			if (i == 5 || i == 7)
				t.hdr.tc = (i == 5) ? 3'h1 : 3'h0;
			if (i == 7)
				t.hdr.length = 10'h002;
			send();
			chk({v.malformed, v.uncor, v.log_hdr, v.nullify, ev}, (i < 7) ? 5'h1F : 5'h00);
			if (i < 7)
				chk(hl, t.raw_hdr);
		end
	endtask

	task automatic s_reset();
		@(posedge clk_i) nrst_i <= 1'b0;
		#1 chk(hl, 128'h0);
		chk({v, ev, pa, sa}, 15'h0000);
		repeat (3) @(posedge clk_i);
		nrst_i <= 1'b1;
	endtask

	task automatic s_overflow();
		logic [127:0] h;
		h = hl;
		base();
		t.overflow = 1'b1;
		send();
		chk({v.uncor, v.log_hdr, v.nullify}, 3'h5);
		chk(hl, h);
	endtask

	task automatic s_unexp();
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_i) sev_u <= i[0];
			base();
			t.hdr.fmt = tec_pkg::FMT_3DW_ND;
			t.hdr.typ = tec_pkg::TYPE_CPL;
			t.actual_dw = 11'h003;
			t.unexp_cpl = 1'b1;
			send();
			chk({v.cor, v.uncor, v.drop, v.log_hdr}, {i[0], ~i[0], 2'h3});
		end
	endtask

	task automatic s_mcast();
		for (int i = 0; i < 2; i++) begin
			base();
			t.mc_blocked = 1'b1;
			t.on_secondary = i[0];
			send();
			chk({pa, sa, v.uncor, v.log_hdr, v.nullify}, {~i[0], i[0], 3'h7});
		end
	endtask

	task automatic s_phy();
		base();
		t.hdr.length = 10'h002;
		t.phy_dll_err = 1'b1;
		send();
		chk({v, ev}, 13'h0000);
	endtask

	task automatic s_ur();
		@(posedge clk_i) sev_r <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			@(posedge clk_i) d3 <= (i == 3 || i == 4);
			ld <= (i == 5);
			repeat (3) @(posedge clk_i);
			base();
			t.to_bridge = (i != 5);
			t.downstream = (i == 5);
			t.claimed = (i != 4);
			t.hdr.ep = (i == 0);
			if (i == 1 || i == 2) begin
				t.hdr.fmt = tec_pkg::FMT_4DW_ND;
				t.hdr.typ = {tec_pkg::TYPE_MSG_HI, 2'h0};
				t.hdr.msg_code = (i == 1) ? tec_pkg::MSG_VDM0 : 8'h55;
			end
			if (i == 3 || i == 4)
				t.hdr.typ = tec_pkg::TYPE_IO;
			send();
			chk({v.unsupported, v.cor, v.uncor}, (i == 3 || i == 4) ? 3'h6 : 3'h5);
			chk(src, (i == 3) ? tec_pkg::TEC_CPL_CLAIMER : (i == 4) ? tec_pkg::TEC_CPL_FUNC0 :
				tec_pkg::TEC_CPL_NONE);
		end
	endtask

	task automatic s_ecrc();
		chk(pe, 1'b0);
		@(posedge clk_i) fen <= 2'h1;
		#1 chk(pe, 1'b1);
		for (int i = 0; i < 3; i++) begin
			base();
			t.hdr.td = 1'b1;
			t.actual_dw = 11'h005;
			t.ecrc_bad = 1'b1;
			t.from_link = (i != 2);
			@(posedge clk_i) fsel <= (i == 1) ? 2'h2 : 2'h1;
			sev_e <= (i == 0);
			send();
			chk({v.ecrc_err, ev}, (i == 1) ? 2'h0 : 2'h3);
			chk({v.cor, v.uncor}, (i == 0) ? 2'h2 : (i == 2) ? 2'h1 : 2'h0);
			chk(v.log_hdr, i == 0);
		end
	endtask

	// ----
	// Sequence
	// ----
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	initial begin
		repeat (3000) @(posedge clk_i);
		errors++;
		final_report();
	end

	initial begin
		{nrst_i, sev_u, sev_e, sev_r, d3, ld, fen, max_payload_size_field} = '0;
		fsel = 2'h1;
		map = 8'h03;
		desc = '0;
		repeat (4) @(posedge clk_i);
		nrst_i <= 1'b1;
		s_malformed();
		s_reset();
		s_overflow();
		s_unexp();
		s_mcast();
		s_phy();
		s_ur();
		s_ecrc();
		final_report();
	end
endmodule
`default_nettype wire
